// ===== common/pitmr_pkg.sv
package pitmr_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] PITMR_OFS_MODE = 4'h0;
	localparam logic [3:0] PITMR_OFS_STATUS = 4'h4;
	localparam logic [3:0] PITMR_OFS_ACK = 4'h8;
	localparam logic [3:0] PITMR_OFS_PEEK = 4'hC;
	localparam logic [3:0] PITMR_OFS_IRQ_MASK = 4'h0;
	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int PITMR_CNT_W = 20;
	localparam int PITMR_TALLY_W = 12;
	localparam int PITMR_RUN_BIT = 24;
	localparam int PITMR_IEN_BIT = 25;
	localparam int PITMR_FLAG_BIT = 0;
	localparam logic [31:0] PITMR_MODE_RST = 32'h000F_FFFF;
	localparam logic [19:0] PITMR_LIMIT_RST = 20'hF_FFFF;
	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int PITMR_DIV = 16;
	localparam int PITMR_DIV_W = 4;
	localparam logic [3:0] PITMR_DIV_LAST = 4'(PITMR_DIV - 1);
	// value view layout
	typedef struct packed {
		logic [11:0] tally;
		logic [19:0] count;
	} pitmr_value_t;
endpackage : pitmr_pkg

// ===== hdl/pitmr_prescale.sv
module pitmr_prescale
	import pitmr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control
	input wire logic hold,
	// time base
	output logic tick
);
	logic [PITMR_DIV_W-1:0] div_q;

	// free divider, frozen while held
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			div_q <= '0;
		end else if (!hold) begin
			div_q <= div_q + 4'h1;
		end
	end

	assign tick = !hold && (div_q == PITMR_DIV_LAST);
endmodule : pitmr_prescale

// ===== hdl/pitmr_timer.sv
// Design decisions made here: the address map and the plain strobed port.
module pitmr_timer
	import pitmr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// core state
	input wire logic debug_halt,
	// interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [19:0] interval_limit_q;
	logic timer_run_enable_q;
	logic interval_irq_enable_q;
	logic active_q;
	logic [19:0] interval_count_q;
	logic [11:0] overflow_tally_q;
	logic interval_reached_flag_q;
	logic [31:0] reg_rdata_q;
	logic tick;
	logic wrap;
	logic ack_rd;
	logic mode_wr;
	pitmr_value_t value;

	// time base divider
	pitmr_prescale u_prescale (
		.mclk(mclk),
		.rst_b(rst_b),
		.hold(debug_halt),
		.tick(tick)
	);

	// decode
	assign mode_wr = reg_wr && (reg_addr == PITMR_OFS_MODE);
	assign ack_rd = reg_rd && (reg_addr == PITMR_OFS_ACK);
	assign wrap = tick && active_q && (interval_count_q == interval_limit_q);

	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	// limit and enables; a new limit touches no counter
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			interval_limit_q <= PITMR_LIMIT_RST;
			timer_run_enable_q <= 1'b0;
			interval_irq_enable_q <= 1'b0;
		end else if (mode_wr) begin
			interval_limit_q <= reg_wdata[PITMR_CNT_W-1:0];
			timer_run_enable_q <= reg_wdata[PITMR_RUN_BIT];
			interval_irq_enable_q <= reg_wdata[PITMR_IEN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// run state sampled while idle and not halted with the count at zero, and again at each wrap
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			active_q <= 1'b0;
		end else if (!debug_halt && interval_count_q == '0 && !active_q) begin
			active_q <= timer_run_enable_q;
		end else if (wrap) begin
			active_q <= timer_run_enable_q;
		end
	end

	// interval counter
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			interval_count_q <= '0;
		end else if (wrap) begin
			interval_count_q <= '0;
		end else if (tick && active_q) begin
			interval_count_q <= interval_count_q + 20'h0_0001;
		end
	end

	// overflow tally; an ack read clears, a wrap in that cycle counts one
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			overflow_tally_q <= '0;
		end else if (ack_rd) begin
			overflow_tally_q <= wrap ? 12'h001 : 12'h000;
		end else if (wrap) begin
			overflow_tally_q <= overflow_tally_q + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// status and interrupt
	// ----------------------------------------------------------------
	// sticky flag, a wrap wins over the ack clear
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			interval_reached_flag_q <= 1'b0;
		end else if (wrap) begin
			interval_reached_flag_q <= 1'b1;
		end else if (ack_rd) begin
			interval_reached_flag_q <= 1'b0;
		end
	end

	assign irq = interval_reached_flag_q && interval_irq_enable_q;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign value.tally = overflow_tally_q;
	assign value.count = interval_count_q;

	// read data stand for one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PITMR_OFS_MODE: begin
					reg_rdata_q <= {6'h00, interval_irq_enable_q,
						timer_run_enable_q, 4'h0, interval_limit_q};
				end
				PITMR_OFS_STATUS: begin
					reg_rdata_q <= {31'h0000_0000, interval_reached_flag_q};
				end
				PITMR_OFS_ACK: begin
					reg_rdata_q <= value;
				end
				PITMR_OFS_PEEK: begin
					reg_rdata_q <= value;
				end
				default: begin
					reg_rdata_q <= '0;
				end
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end

	assign reg_rdata = reg_rdata_q;
endmodule : pitmr_timer

// ===== verif/pitmr_timer_sva.sv
module pitmr_timer_chk
	import pitmr_pkg::*;
(
	// watched ports
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic debug_halt,
	input wire logic irq
);
	// single clock domain
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	AST_ACK: assert property (debug_halt && reg_rd
		&& reg_addr == 4'h8 |=> !irq) else $error("irq after ack");
	AST_PEEK: assert property (debug_halt && reg_rd
		&& reg_addr == 4'hC ##1 reg_rd && reg_addr == 4'hC
		|=> $stable(reg_rdata)) else $error("peek moved");
	AST_HALT: assert property (debug_halt && !reg_rd
		&& !reg_wr |=> $stable(irq)) else $error("irq moved in halt");
	AST_STAT: assert property (reg_rd && reg_addr == 4'h4
		|=> reg_rdata[31:1] == '0) else $error("status spare set");
	AST_MODE: assert property (reg_wr && reg_addr == 4'h0
		##1 reg_rd && reg_addr == 4'h0
		|=> reg_rdata[19:0] == $past(reg_wdata[19:0], 2))
		else $error("limit readback");
	AST_HOLE: assert property (reg_rd
		&& reg_addr[1:0] != 2'h0 |=> reg_rdata == '0)
		else $error("unmapped read");
	AST_IEN: assert property (reg_wr && reg_addr == 4'h0
		&& !reg_wdata[25] |=> !irq) else $error("irq disabled");
	AST_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("data outside read");
endmodule : pitmr_timer_chk
bind pitmr_timer pitmr_timer_chk chk_u (.mclk(mclk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt),
	.irq(irq));

// ===== verif/tb.sv
module tb
	import pitmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic debug_halt = 1'b0, rd_d = 1'b0, irq;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, exp_q[$];
	int failures = 0, tests_run = 0, cyc = 0, seed = 50084, lim, t0;
	// clock and cycle count
	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	pitmr_timer dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .debug_halt(debug_halt), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		tests_run++;
		if (got !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : chk
	// read data meets the oldest note
	always @(posedge mclk) begin
		if (rd_d)
			chk(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end
	// one access: write, or read noting the expected data
	task automatic acc(input bit w, input logic [3:0] a,
		input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w)
			exp_q.push_back(d);
		@(posedge mclk);
	endtask : acc
	task automatic idle();
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : idle
	task automatic test_done();
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task automatic wirq();
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
			@(posedge mclk);
		if (irq !== 1'b1) begin
			failures++;
			test_done();
		end
	endtask : wirq
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		idle();
		acc(0, 4'h0, PITMR_MODE_RST);
		acc(0, 4'h8, 32'h0000_0000);
		acc(1, 4'h0, 32'h0300_0003);
		acc(0, 4'h0, 32'h0300_0003);
		acc(0, 4'h2, 32'h0000_0000);
		idle();
		$display("regs done");
		wirq();
		debug_halt <= 1'b1;
		repeat (40) @(posedge mclk);
		acc(0, 4'hC, 32'h0010_0000);
		acc(0, 4'hC, 32'h0010_0000);
		acc(0, 4'h8, 32'h0010_0000);
		acc(0, 4'hC, 32'h0000_0000);
		acc(0, 4'h4, 32'h0000_0000);
		idle();
		debug_halt <= 1'b0;
		$display("halt done");
		for (int n = 0; n < 3; n++) begin
			lim = $random(seed) & 7;
			acc(1, 4'h0, 32'h0300_0000 | lim);
			idle();
			wirq();
			t0 = cyc;
			acc(0, 4'h8, 32'h0010_0000);
			idle();
			wirq();
			chk(32'(cyc - t0), 32'((lim + 1) * PITMR_DIV));
			acc(0, 4'h8, 32'h0010_0000);
			idle();
		end
		$display("interval done");
		acc(1, 4'h0, 32'h0200_0003);
		idle();
		wirq();
		acc(0, 4'h8, 32'h0010_0000);
		idle();
		repeat (200) @(posedge mclk);
		acc(0, 4'hC, 32'h0000_0000);
		acc(1, 4'h0, 32'h0000_0003);
		idle();
		$display("stop done");
		test_done();
	end
endmodule : tb
